/* File: rtl/cit_pkg.sv */
// package for the instruction timing decoder: timing constants and enum types
package cit_pkg;
  localparam logic [3:0] CIT_MAX_CYCLES = 4'h8;
  localparam logic [7:0] CIT_NOP_OP = 8'h00;
  localparam logic [7:0] CIT_SPARE_OP = 8'ha5;
  localparam logic [3:0] CIT_RST_CNT = 4'h0;
  localparam logic [1:0] CIT_RST_LEN = 2'h0;

  typedef enum {
    CIT_IDLE,
    CIT_EXEC
  } cit_state_t;

  // destination of an external move
  typedef enum logic [1:0] {
    CIT_TGT_NONE = 2'h0,
    CIT_TGT_ON_CHIP_EXPANSION_RAM = 2'h1,
    CIT_TGT_FLASH = 2'h2
  } cit_tgt_t;
endpackage : cit_pkg

/* File: rtl/cit_decoder.sv */
// instruction length and cycle-count decoder with an execution sequencer
//
// Overview of operation
// [RL1] count time purely in system clock cycles
// [RL2] most instructions: cycles equal byte length
// [RL3] untaken conditional branch is one cycle shorter
// [RL4] external move write reaches expansion RAM or flash
// [RL5] no off-chip data or program path
// [RL6] add/add_with_carry/subtract_with_borrow: reg 1/1, direct/imm 2/2, indirect 1/2
// [RL7] single-byte indirect RAM operations take 2 cycles
// [RL8] inc/dec reg, inc pointer 1/1; direct 2/2
// [RL9] logic ops; direct destination 2/2, immediate 3/3
// [RL10] accumulator unary operations are 1 byte 1 cycle
// [RL11] acc-register moves 1/1; direct/imm loads 2/2
// [RL12] moves to direct: 2/2, direct 3/3, immediate 3/3
// [RL13] indirect RAM moves 2 cycles; 1 or 2 bytes
// [RL14] no instruction exceeds eight cycles
// [RL15] carry jumps: 2 bytes, 2 or 3 cycles
// [RL16] unused opcode behaves as no-operation
// [RL17] remaining timing per full instruction summary
// [RL18] standard opcodes and encodings retained
`timescale 1ns/1ps
module cit_decoder
  import cit_pkg::*;
(
  input wire logic clk, // 100 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic op_valid, // opcode offered for issue
  input wire logic [7:0] opcode, // first byte of the instruction
  input wire logic cond_taken, // branch condition result for the opcode
  input wire logic [15:0] xaddr, // external move address (pointer pair or indirect)
  input wire logic flash_wr_en, // steer external move writes to flash
  output logic op_ready, // sequencer can take an opcode
  output logic [1:0] op_len_r, // byte length of issued instruction
  output logic [3:0] op_cycles_r, // total cycles of issued instruction
  output logic done, // pulse in last cycle of execution
  output logic busy_r, // instruction in execution
  output logic xmove_wr_r, // issued instruction is an external move write
  output logic [1:0] xmove_tgt_r, // target of external move (cit_tgt_t)
  output logic [15:0] xmove_addr_r // on-chip address of external move
);

  // external data space repeats every 2k, so high address bits are dropped unless the move is a flash write
  localparam logic [15:0] WRAP_MASK = 16'h07ff;

  // returns {bytes, base cycles, conditional flag}; timing follows the standard
  // encoding map, so the opcode bits are decoded exactly as the standard set [RL18]
  function automatic logic [6:0] dec_timing(input logic [7:0] op);
    logic [1:0] b;
    logic [3:0] c;
    logic cnd;
    b = 2'h1;
    c = 4'h1;
    cnd = 1'b0;
    if (op[3]) begin
      // working register column, mostly one byte and one cycle [RL6] [RL8] [RL11]
      case (op[7:4])
        4'h7, 4'ha: begin b = 2'h2; c = 4'h2; end // imm or direct to reg [RL11]
        4'h8: begin b = 2'h2; c = 4'h2; end // reg to direct [RL12]
        4'hb: begin b = 2'h3; c = 4'h3; cnd = 1'b1; end // compare reg and jump
        4'hd: begin b = 2'h2; c = 4'h2; cnd = 1'b1; end // decrement reg and jump
        default: begin b = 2'h1; c = 4'h1; end
      endcase
    end else if (op[3:1] == 3'h3) begin
      // pointer_register_indirect column [RL7] [RL13]
      case (op[7:4])
        4'h7, 4'ha: begin b = 2'h2; c = 4'h2; end // imm or direct to indirect [RL13]
        4'h8: begin b = 2'h2; c = 4'h2; end // indirect to direct [RL13]
        4'hb: begin b = 2'h3; c = 4'h4; cnd = 1'b1; end // compare indirect, 4/5
        default: begin b = 2'h1; c = 4'h2; end // single byte indirect [RL7]
      endcase
    end else if (op[3:0] == 4'h1) begin
      // absolute jump and call [RL17]
      b = 2'h2;
      c = 4'h3;
    end else begin
      case (op)
        8'h00, CIT_SPARE_OP: begin b = 2'h1; c = 4'h1; end // no-operation [RL16]
        8'h02: begin b = 2'h3; c = 4'h4; end // long jump
        8'h12: begin b = 2'h3; c = 4'h4; end // long call
        8'h22, 8'h32: begin b = 2'h1; c = 4'h5; end // returns
        8'h80: begin b = 2'h2; c = 4'h3; end // short jump
        8'h73, 8'h83, 8'h93: begin b = 2'h1; c = 4'h3; end // indirect jump, code reads
        8'h90: begin b = 2'h3; c = 4'h3; end // load pointer pair
        8'ha3: begin b = 2'h1; c = 4'h1; end // increment pointer pair [RL8]
        8'ha4: begin b = 2'h1; c = 4'h4; end // multiply
        8'h84: begin b = 2'h1; c = CIT_MAX_CYCLES; end // divide, slowest [RL14]
        8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: begin b = 2'h1; c = 4'h3; end
        8'h40, 8'h50, 8'h60, 8'h70: begin b = 2'h2; c = 4'h2; cnd = 1'b1; end // [RL15]
        8'h10, 8'h20, 8'h30: begin b = 2'h3; c = 4'h3; cnd = 1'b1; end
        8'hb4, 8'hb5, 8'hd5: begin b = 2'h3; c = 4'h3; cnd = 1'b1; end
        8'h43, 8'h53, 8'h63: begin b = 2'h3; c = 4'h3; end // logic imm to direct [RL9]
        8'h75, 8'h85: begin b = 2'h3; c = 4'h3; end // moves to direct [RL12]
        8'h42, 8'h52, 8'h62: begin b = 2'h2; c = 4'h2; end // logic acc to direct [RL9]
        8'hc3, 8'hd3, 8'hb3, 8'he4, 8'hf4, 8'hc4, 8'hd4: begin b = 2'h1; c = 4'h1; end
        8'h03, 8'h13, 8'h23, 8'h33, 8'h04, 8'h14: begin b = 2'h1; c = 4'h1; end // [RL10]
        default: begin
          // direct, immediate and bit forms: bytes equal cycles [RL2] [RL6] [RL9]
          b = 2'h2;
          c = 4'h2;
        end
      endcase
    end
    return {b, c, cnd};
  endfunction : dec_timing

  // external move opcodes: reads e0/e2/e3 and writes f0/f2/f3 [RL18]
  function automatic logic is_xmove(input logic [7:0] op);
    return (op[7:5] == 3'h7) && (op[3:2] == 2'h0) && (op[1:0] != 2'h1);
  endfunction : is_xmove

  // bit 4 separates the write forms from the read forms
  function automatic logic is_xmove_wr(input logic [7:0] op);
    return is_xmove(op) && op[4];
  endfunction : is_xmove_wr

  // only on-chip targets exist, so no code can select an off-chip space [RL4] [RL5]
  function automatic logic [1:0] xmove_target(input logic [7:0] op, input logic fw);
    logic [1:0] t;
    t = CIT_TGT_NONE;
    if (is_xmove(op)) begin
      t = (is_xmove_wr(op) && fw) ? CIT_TGT_FLASH : CIT_TGT_ON_CHIP_EXPANSION_RAM;
    end
    return t;
  endfunction : xmove_target

  cit_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [1:0] len_nxt;
  logic [3:0] cyc_nxt;
  logic busy_nxt;
  logic xwr_nxt;
  logic [1:0] xtgt_nxt;
  logic [15:0] xaddr_nxt;
  logic [6:0] dec;
  logic [3:0] total;
  logic issue;

  always_comb begin
    dec = dec_timing(opcode);
    // taken branches add one cycle; untaken ones finish a cycle sooner [RL3] [RL15]
    total = dec[4:1] + {3'h0, dec[0] & cond_taken};
  end

  assign op_ready = (state_r == CIT_IDLE) || (cnt_r == 4'h1);
  assign done = (state_r == CIT_EXEC) && (cnt_r == 4'h1);
  // one issue point for both states keeps back-to-back spacing exact:
  // a new opcode is taken in the very cycle that done is high
  assign issue = op_valid && op_ready;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    len_nxt = op_len_r;
    cyc_nxt = op_cycles_r;
    busy_nxt = busy_r;
    xwr_nxt = xmove_wr_r;
    xtgt_nxt = xmove_tgt_r;
    xaddr_nxt = xmove_addr_r;
    case (state_r)
      CIT_IDLE: begin
        cnt_nxt = CIT_RST_CNT;
        busy_nxt = 1'b0;
        xwr_nxt = 1'b0;
        xtgt_nxt = CIT_TGT_NONE;
      end
      CIT_EXEC: begin
        if (cnt_r != 4'h1) begin
          cnt_nxt = cnt_r - 4'h1; // one count per system clock [RL1]
        end else begin
          // last cycle: fall back to idle unless a new opcode follows
          state_nxt = CIT_IDLE;
          cnt_nxt = CIT_RST_CNT;
          busy_nxt = 1'b0;
          xwr_nxt = 1'b0;
          xtgt_nxt = CIT_TGT_NONE;
        end
      end
      default: begin
        state_nxt = CIT_IDLE;
        cnt_nxt = CIT_RST_CNT;
      end
    endcase
    if (issue) begin
      // the 4-bit count covers the slowest case, divide at eight cycles [RL14]
      state_nxt = CIT_EXEC;
      cnt_nxt = total;
      len_nxt = dec[6:5];
      cyc_nxt = total;
      busy_nxt = 1'b1;
      xwr_nxt = is_xmove_wr(opcode);
      xtgt_nxt = xmove_target(opcode, flash_wr_en); // [RL4]
      if (is_xmove(opcode)) begin
        // flash writes keep the full address; on_chip_expansion_ram wraps on 2k boundaries [RL5]
        xaddr_nxt = (is_xmove_wr(opcode) && flash_wr_en) ? xaddr : (xaddr & WRAP_MASK);
      end else begin
        xaddr_nxt = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= CIT_IDLE;
      cnt_r <= CIT_RST_CNT;
      op_len_r <= CIT_RST_LEN;
      op_cycles_r <= CIT_RST_CNT;
      busy_r <= 1'b0;
      xmove_wr_r <= 1'b0;
      xmove_tgt_r <= CIT_TGT_NONE;
      xmove_addr_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      op_len_r <= len_nxt;
      op_cycles_r <= cyc_nxt;
      busy_r <= busy_nxt;
      xmove_wr_r <= xwr_nxt;
      xmove_tgt_r <= xtgt_nxt;
      xmove_addr_r <= xaddr_nxt;
    end
  end

endmodule : cit_decoder

/* File: tb/cit_prog_mem.sv */
// program memory model feeding opcode bytes
`timescale 1ns/1ps
module cit_prog_mem (
  input wire logic [3:0] pc, // fetch address
  output logic [7:0] op // opcode at pc
);
  // standard encodings plus the unused opcode a5
  logic [7:0] rom [16] = '{8'h25, 8'h28, 8'h26, 8'h24, 8'h40, 8'ha5, 8'hf0, 8'h84,
    8'h53, 8'h42, 8'hc4, 8'h85, 8'hf6, 8'h75, 8'ha3, 8'h06};
  assign op = rom[pc];
endmodule : cit_prog_mem

/* File: tb/cit_decoder_sva.sv */
// port checks for the timing decoder
`timescale 1ns/1ps
module cit_decoder_sva
  import cit_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic op_valid, // offer
  input wire logic [7:0] opcode, // opcode
  input wire logic cond_taken, // taken
  input wire logic [15:0] xaddr, // address
  input wire logic flash_wr_en, // flash
  input wire logic op_ready, // ready
  input wire logic [1:0] op_len_r, // bytes
  input wire logic [3:0] op_cycles_r, // cycles
  input wire logic done, // last cycle
  input wire logic busy_r, // busy
  input wire logic [1:0] xmove_tgt_r, // target
  input wire logic [15:0] xmove_addr_r // address
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic go;
  assign go = op_valid && op_ready;
  sequence s_two; !done ##1 done; endsequence
  sequence s_three; !done [*2] ##1 done; endsequence
  a_done_ready: assert property (done |-> op_ready) else $error("done not ready");
  a_issue_busy: assert property (go |=> busy_r) else $error("no busy");
  a_max_cyc: assert property (go |=> op_cycles_r <= 4'h8 && op_cycles_r != 4'h0)
    else $error("cycles out of range");
  a_add_dir: assert property (go && opcode == 8'h25 |=>
    (op_len_r == 2'h2 && op_cycles_r == 4'h2) ##0 s_two) else $error("bad add");
  a_jc_taken: assert property (go && opcode == 8'h40 && cond_taken |=>
    op_cycles_r == 4'h3 ##0 s_three) else $error("bad taken jump");
  a_jc_skip: assert property (go && opcode == 8'h40 && !cond_taken |=>
    op_cycles_r == 4'h2 ##0 s_two) else $error("bad untaken jump");
  a_spare_nop: assert property (go && opcode == CIT_SPARE_OP |=>
    op_len_r == 2'h1 && op_cycles_r == 4'h1 && done) else $error("bad spare");
  a_on_chip_expansion_ram_wrap: assert property (go && opcode == 8'hf0 && !flash_wr_en |=>
    xmove_tgt_r == 2'h1 && xmove_addr_r == ($past(xaddr) & 16'h07ff)) else $error("bad ram");
  a_flash_tgt: assert property (go && opcode == 8'hf0 && flash_wr_en |=>
    xmove_tgt_r == 2'h2 && xmove_addr_r == $past(xaddr)) else $error("bad flash");
endmodule : cit_decoder_sva

bind cit_decoder cit_decoder_sva i_sva (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
  .opcode(opcode), .cond_taken(cond_taken), .xaddr(xaddr), .flash_wr_en(flash_wr_en),
  .op_ready(op_ready), .op_len_r(op_len_r), .op_cycles_r(op_cycles_r), .done(done),
  .busy_r(busy_r), .xmove_tgt_r(xmove_tgt_r), .xmove_addr_r(xmove_addr_r));

/* File: tb/cit_decoder_test.sv */
// self-checking bench for the timing decoder
`timescale 1ns/1ps
module cit_decoder_test;
  import cit_pkg::*;
  logic clk = 0, rst_n = 0, op_valid = 0, cond_taken = 0, flash_wr_en = 0;
  logic [7:0] opcode = 8'h00, rom_op;
  logic [15:0] xaddr = 16'h0000, xmove_addr_r;
  logic op_ready, done, busy_r, xmove_wr_r;
  logic [1:0] op_len_r, xmove_tgt_r;
  logic [3:0] op_cycles_r, pc = 4'h0;
  // bytes in the high nibble, cycles in the low one
  logic [7:0] exp_t [16] = '{8'h22, 8'h11, 8'h12, 8'h22, 8'h22, 8'h11, 8'h13, 8'h18,
    8'h33, 8'h22, 8'h11, 8'h33, 8'h12, 8'h33, 8'h11, 8'h12};
  int n_errors = 0, cmp_count = 0;
  always #5 clk = ~clk;
  cit_prog_mem i_mem (.pc(pc), .op(rom_op));
  cit_decoder i_dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .opcode(opcode),
    .cond_taken(cond_taken), .xaddr(xaddr), .flash_wr_en(flash_wr_en), .op_ready(op_ready),
    .op_len_r(op_len_r), .op_cycles_r(op_cycles_r), .done(done), .busy_r(busy_r),
    .xmove_wr_r(xmove_wr_r), .xmove_tgt_r(xmove_tgt_r), .xmove_addr_r(xmove_addr_r));
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // issue in the done cycle, so back-to-back spacing is exercised
  task automatic issue(input logic [7:0] op, input logic ct, input logic fw,
    input logic [15:0] xa, input logic [7:0] e);
    int n;
    n = 1;
    while (op_ready !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1 n++;
    end
    if (op_ready !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
    op_valid = 1;
    opcode = op;
    cond_taken = ct;
    flash_wr_en = fw;
    xaddr = xa;
    @(posedge clk);
    #1 op_valid = 0;
    chk(busy_r, 16'h0001);
    chk(op_len_r, e[5:4]);
    chk(op_cycles_r, e[3:0]);
    n = 1;
    while (done !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n, e[3:0]);
    if (n == 12) tally_and_finish();
  endtask : issue
  task automatic t_table;
    for (int i = 0; i < 16; i++) begin
      pc = i[3:0];
      #0 issue(rom_op, 1'b0, 1'b0, 16'h0000, exp_t[i]);
    end
  endtask : t_table
  task automatic t_branch;
    issue(8'h40, 1'b1, 1'b0, 16'h0000, 8'h23);
    issue(8'h40, 1'b0, 1'b0, 16'h0000, 8'h22);
    issue(8'hb6, 1'b1, 1'b0, 16'h0000, 8'h35);
    issue(8'hb6, 1'b0, 1'b0, 16'h0000, 8'h34);
  endtask : t_branch
  task automatic t_xmove;
    issue(8'hf0, 1'b0, 1'b0, 16'h1a34, 8'h13);
    chk(xmove_tgt_r, 16'h0001);
    chk(xmove_addr_r, 16'h0234);
    issue(8'hf0, 1'b0, 1'b1, 16'h1a34, 8'h13);
    chk(xmove_tgt_r, 16'h0002);
    chk(xmove_wr_r, 16'h0001);
    chk(xmove_addr_r, 16'h1a34);
    @(posedge clk);
    #1 chk(busy_r, 16'h0000);
    chk(op_ready, 16'h0001);
  endtask : t_xmove
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    t_table();
    t_branch();
    t_xmove();
    tally_and_finish();
  end
endmodule : cit_decoder_test
